// ---- hw/jcp_device.sv ----
// Device end: test port controller, instruction decode, config memories A/B.
// Assumes tck, tms, tdi arrive asynchronously and are sampled by hclk.
`timescale 1ns/1ps
`default_nettype none
module jcp_device
    import jcp_pkg::*;
#(
    parameter int          PROG_CYCLES = PROG_CYC,
    parameter int          CAL_CYCLES  = CAL_CYC,
    parameter logic [31:0] ID_CODE     = ID_VALUE
) (
    input  wire logic         hclk,
    input  wire logic         hresetn,
    jcp_link_if.dev           link,
    output logic [UREG_W-1:0] cfg_a,
    output logic [UREG_W-1:0] cfg_b,
    output logic              normal_op_suspended,
    output logic              cal_active
);
    typedef enum logic [1:0] {
        PATH_BYP = 2'h0,
        PATH_USR = 2'h1,
        PATH_IDR = 2'h3
    } jcp_path_type;

    typedef struct packed {
        logic [2:0]        tck_s;
        logic [1:0]        tms_s;
        logic [1:0]        tdi_s;
        jcp_tap_type       tap;
        logic [IR_W-1:0]   ir_sh;
        logic [IR_W-1:0]   ir;
        logic [UREG_W-1:0] dr_sh;
        logic [UREG_W-1:0] user;
        logic [UREG_W-1:0] mem_a;
        logic [UREG_W-1:0] mem_b;
        logic              tdo;
        logic              tdo_oe;
        logic [15:0]       busy_cnt;
        logic [15:0]       cal_cnt;
    } jcp_dev_state_type;

    localparam jcp_dev_state_type DEV_RST = '{
        tck_s: 3'h0, tms_s: 2'h3, tdi_s: 2'h0, tap: TAP_TLR,
        ir_sh: INS_IDCODE, ir: INS_IDCODE, dr_sh: UREG_RST, user: UREG_RST,
        mem_a: UREG_RST, mem_b: UREG_RST, tdo: 1'b0, tdo_oe: 1'b0,
        busy_cnt: 16'h0, cal_cnt: 16'h0};

    jcp_dev_state_type r_r;
    jcp_dev_state_type r_nxt;

    // ------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------
    function automatic jcp_tap_type tap_next(input jcp_tap_type s, input logic tms);
        case (s)
            TAP_TLR: tap_next = tms ? TAP_TLR : TAP_RTI;
            TAP_RTI: tap_next = tms ? TAP_SDS : TAP_RTI;
            TAP_SDS: tap_next = tms ? TAP_SIS : TAP_CDR;
            TAP_CDR: tap_next = tms ? TAP_E1D : TAP_SDR;
            TAP_SDR: tap_next = tms ? TAP_E1D : TAP_SDR;
            TAP_E1D: tap_next = tms ? TAP_UDR : TAP_PDR;
            TAP_PDR: tap_next = tms ? TAP_E2D : TAP_PDR;
            TAP_E2D: tap_next = tms ? TAP_UDR : TAP_SDR;
            TAP_UDR: tap_next = tms ? TAP_SDS : TAP_RTI;
            TAP_SIS: tap_next = tms ? TAP_TLR : TAP_CIR;
            TAP_CIR: tap_next = tms ? TAP_E1I : TAP_SIR;
            TAP_SIR: tap_next = tms ? TAP_E1I : TAP_SIR;
            TAP_E1I: tap_next = tms ? TAP_UIR : TAP_PIR;
            TAP_PIR: tap_next = tms ? TAP_E2I : TAP_PIR;
            TAP_E2I: tap_next = tms ? TAP_UIR : TAP_SIR;
            TAP_UIR: tap_next = tms ? TAP_SDS : TAP_RTI;
            default: tap_next = TAP_TLR;
        endcase
    endfunction : tap_next

    function automatic jcp_path_type dr_path(input logic [IR_W-1:0] ir);
        case (ir)
            INS_ADDR_USER: dr_path = PATH_USR;
            INS_IDCODE:    dr_path = PATH_IDR;
            default:       dr_path = PATH_BYP;
        endcase
    endfunction : dr_path

    function automatic logic [UREG_W-1:0] dr_shift(input logic [UREG_W-1:0] sh, input logic tdi,
                                                   input jcp_path_type p);
        case (p)
            PATH_USR: dr_shift = {tdi, sh[UREG_W-1:1]};
            PATH_IDR: dr_shift = {64'h0, tdi, sh[ID_W-1:1]};
            default:  dr_shift = {{(UREG_W-1){1'b0}}, tdi};
        endcase
    endfunction : dr_shift

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    logic            tck_rise;
    logic            tck_fall;
    logic            tms_q;
    logic            tdi_q;
    jcp_tap_type     tap_new;
    logic [IR_W-1:0] ir_eff;

    always_comb begin
        r_nxt = r_r;
        r_nxt.tck_s = {r_r.tck_s[1:0], link.tck};
        r_nxt.tms_s = {r_r.tms_s[0], link.tms};
        r_nxt.tdi_s = {r_r.tdi_s[0], link.tdi};
        tck_rise = r_r.tck_s[1] & ~r_r.tck_s[2];
        tck_fall = ~r_r.tck_s[1] & r_r.tck_s[2];
        tms_q    = r_r.tms_s[1];
        tdi_q    = r_r.tdi_s[1];
        tap_new  = tap_next(r_r.tap, tms_q);
        // Instruction updated on this edge already counts at entry to idle
        ir_eff   = (r_r.tap == TAP_UIR) ? r_r.ir_sh : r_r.ir;

        if (r_r.busy_cnt != 16'h0) begin
            r_nxt.busy_cnt = r_r.busy_cnt - 16'h1;
        end
        // Calibration needs no further port activity
        if (r_r.cal_cnt != 16'h0) begin
            r_nxt.cal_cnt = r_r.cal_cnt - 16'h1;
        end

        if (tck_rise) begin
            r_nxt.tap = tap_new;
            case (r_r.tap)
                TAP_TLR: r_nxt.ir = INS_IDCODE;
                TAP_CIR: r_nxt.ir_sh = INS_IDCODE;
                TAP_SIR: r_nxt.ir_sh = {tdi_q, r_r.ir_sh[IR_W-1:1]};
                TAP_UIR: r_nxt.ir = r_r.ir_sh;
                TAP_CDR: begin
                    case (dr_path(r_r.ir))
                        PATH_USR: r_nxt.dr_sh = r_r.user;
                        PATH_IDR: r_nxt.dr_sh = {64'h0, ID_CODE};
                        default:  r_nxt.dr_sh = UREG_RST;
                    endcase
                end
                TAP_SDR: r_nxt.dr_sh = dr_shift(r_r.dr_sh, tdi_q, dr_path(r_r.ir));
                TAP_UDR: begin
                    if (dr_path(r_r.ir) == PATH_USR) begin
                        r_nxt.user = r_r.dr_sh;
                    end
                end
                default: ;
            endcase

            // Operations executed on entry to Run-Test/Idle
            if (tap_new == TAP_RTI && r_r.tap != TAP_RTI) begin
                case (ir_eff)
                    INS_ERASE_A: begin
                        r_nxt.mem_a    = UREG_RST;
                        r_nxt.busy_cnt = 16'(PROG_CYCLES);
                    end
                    INS_ERASE_B: begin
                        r_nxt.mem_b    = UREG_RST;
                        r_nxt.busy_cnt = 16'(PROG_CYCLES);
                    end
                    INS_PROG_A: begin
                        r_nxt.mem_a    = r_r.mem_a | r_r.user;
                        r_nxt.busy_cnt = 16'(PROG_CYCLES);
                    end
                    INS_PROG_B: begin
                        r_nxt.mem_b    = r_r.mem_b | (r_r.user & CAP_MASK_B);
                        r_nxt.busy_cnt = 16'(PROG_CYCLES);
                    end
                    INS_VERIFY_A: begin
                        // Readback is zeros while the select bit is set
                        r_nxt.user = r_r.mem_a[CFG_SEL_BIT] ? UREG_RST : r_r.mem_a;
                    end
                    INS_VERIFY_B: r_nxt.user = r_r.mem_b;
                    INS_AUTOCAL:  r_nxt.cal_cnt = 16'(CAL_CYCLES);
                    default: ;
                endcase
            end
        end

        if (tck_fall) begin
            r_nxt.tdo_oe = (r_r.tap == TAP_SIR) || (r_r.tap == TAP_SDR);
            r_nxt.tdo    = (r_r.tap == TAP_SIR) ? r_r.ir_sh[0] : r_r.dr_sh[0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            r_r <= DEV_RST;
        end else begin
            r_r <= r_nxt;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign link.tdo            = r_r.tdo;
    assign link.tdo_oe         = r_r.tdo_oe;
    assign cfg_a               = r_r.mem_a;
    assign cfg_b               = r_r.mem_b;
    assign normal_op_suspended = (r_r.busy_cnt != 16'h0);
    assign cal_active          = (r_r.cal_cnt != 16'h0);
endmodule : jcp_device
`default_nettype wire

// ---- hw/jcp_host.sv ----
// Host end: AHB-Lite register slave that runs scan sequences on the link.
// Assumes one AHB-Lite master, single word transfers; TCK made by divider.
`timescale 1ns/1ps
`default_nettype none
module jcp_host
    import jcp_pkg::*;
#(
    parameter int HALF = TCK_HALF
) (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    jcp_link_if.host         link
);
    typedef struct packed {
        logic              tck;
        logic [7:0]        div;
        jcp_op_type        op;
        logic              busy;
        logic [7:0]        stp;
        logic [7:0]        len;
        logic [IR_W-1:0]   ir;
        logic [UREG_W-1:0] tx;
        logic [UREG_W-1:0] rx;
        logic              tms;
        logic              tdi;
        logic [1:0]        tdo_s;
        logic              dph_wr;
        logic [7:0]        dph_addr;
        logic [31:0]       rdata;
    } jcp_host_state_type;

    localparam jcp_host_state_type HOST_RST = '{
        tck: 1'b0, div: 8'h0, op: OP_RESET, busy: 1'b0, stp: 8'h0, len: 8'h1,
        ir: INS_BYPASS, tx: UREG_RST, rx: UREG_RST, tms: 1'b1, tdi: 1'b0,
        tdo_s: 2'h3, dph_wr: 1'b0, dph_addr: 8'h0, rdata: 32'h0};

    jcp_host_state_type r_r;
    jcp_host_state_type r_nxt;

    // ------------------------------------------------------------
    // Sequence helpers
    // ------------------------------------------------------------
    function automatic logic [7:0] pre_len(input jcp_op_type op);
        case (op)
            OP_IR:   pre_len = IR_PRE;
            OP_DR:   pre_len = DR_PRE;
            default: pre_len = 8'h0;
        endcase
    endfunction : pre_len

    function automatic logic [7:0] shift_len(input jcp_op_type op, input logic [7:0] len);
        case (op)
            OP_IR:   shift_len = 8'(IR_W);
            OP_DR:   shift_len = len;
            default: shift_len = 8'h0;
        endcase
    endfunction : shift_len

    function automatic logic [7:0] total_len(input jcp_op_type op, input logic [7:0] len);
        case (op)
            OP_RESET: total_len = RST_STEPS;
            OP_IDLE:  total_len = len;
            default:  total_len = pre_len(op) + shift_len(op, len) + POST_LEN;
        endcase
    endfunction : total_len

    function automatic logic step_tms(input jcp_op_type op, input logic [7:0] s, input logic [7:0] len);
        logic [7:0] p;
        logic [7:0] e;
        p = pre_len(op);
        e = p + shift_len(op, len);
        case (op)
            OP_RESET: step_tms = 1'b1;
            OP_IDLE:  step_tms = 1'b0;
            OP_IR:    step_tms = (s < p) ? (s == 8'd1 || s == 8'd2) : (s == e - 8'd1 || s == e);
            default:  step_tms = (s < p) ? (s == 8'd1) : (s == e - 8'd1 || s == e);
        endcase
    endfunction : step_tms

    function automatic logic step_tdi(input jcp_op_type op, input logic [7:0] s,
                                      input logic [IR_W-1:0] ir, input logic [UREG_W-1:0] tx);
        logic [7:0] i;
        i = s - pre_len(op);
        case (op)
            OP_IR:   step_tdi = (i < 8'(IR_W)) ? ir[i[2:0]] : 1'b0;
            OP_DR:   step_tdi = (i < 8'(UREG_W)) ? tx[i[6:0]] : 1'b0;
            default: step_tdi = 1'b0;
        endcase
    endfunction : step_tdi

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    logic       addr_ok;
    logic [7:0] idx;
    logic [7:0] stp_inc;
    jcp_op_type op_new;

    always_comb begin
        r_nxt         = r_r;
        r_nxt.tdo_s   = {r_r.tdo_s[0], link.tdo_line};
        addr_ok       = hsel && htrans[1] && hready;
        idx           = r_r.stp - pre_len(r_r.op);
        stp_inc       = r_r.stp + 8'h1;
        op_new        = jcp_op_type'(hwdata[1:0]);

        // Address phase
        r_nxt.dph_wr   = addr_ok && hwrite;
        r_nxt.dph_addr = haddr[7:0];
        if (addr_ok && !hwrite) begin
            case (haddr[7:0])
                REG_CMD:    r_nxt.rdata = {30'h0, r_r.op};
                REG_STATUS: r_nxt.rdata = {31'h0, r_r.busy};
                REG_IR:     r_nxt.rdata = {27'h0, r_r.ir};
                REG_LEN:    r_nxt.rdata = {24'h0, r_r.len};
                REG_TX0:    r_nxt.rdata = r_r.tx[31:0];
                REG_TX1:    r_nxt.rdata = r_r.tx[63:32];
                REG_TX2:    r_nxt.rdata = r_r.tx[95:64];
                REG_RX0:    r_nxt.rdata = r_r.rx[31:0];
                REG_RX1:    r_nxt.rdata = r_r.rx[63:32];
                REG_RX2:    r_nxt.rdata = r_r.rx[95:64];
                default:    r_nxt.rdata = 32'h0;
            endcase
        end

        // Sequence engine: TMS/TDI change with TCK low, TDO taken at step end
        if (r_r.busy) begin
            if (r_r.div == 8'(HALF - 1)) begin
                r_nxt.tck = 1'b1;
                r_nxt.div = r_r.div + 8'h1;
            end else if (r_r.div == 8'(2 * HALF - 1)) begin
                r_nxt.tck = 1'b0;
                r_nxt.div = 8'h0;
                if ((r_r.op == OP_IR || r_r.op == OP_DR) && r_r.stp >= pre_len(r_r.op)
                    && idx < shift_len(r_r.op, r_r.len) && idx < 8'(UREG_W)) begin
                    r_nxt.rx[idx[6:0]] = r_r.tdo_s[1];
                end
                r_nxt.stp = stp_inc;
                if (stp_inc == total_len(r_r.op, r_r.len)) begin
                    r_nxt.busy = 1'b0;
                    r_nxt.tdi  = 1'b0;
                end else begin
                    r_nxt.tms = step_tms(r_r.op, stp_inc, r_r.len);
                    r_nxt.tdi = step_tdi(r_r.op, stp_inc, r_r.ir, r_r.tx);
                end
            end else begin
                r_nxt.div = r_r.div + 8'h1;
            end
        end

        // Data phase writes; a command while busy is ignored
        if (r_r.dph_wr) begin
            case (r_r.dph_addr)
                REG_CMD: begin
                    if (!r_r.busy) begin
                        r_nxt.op   = op_new;
                        r_nxt.busy = 1'b1;
                        r_nxt.stp  = 8'h0;
                        r_nxt.div  = 8'h0;
                        r_nxt.tck  = 1'b0;
                        r_nxt.rx   = UREG_RST;
                        r_nxt.tms  = step_tms(op_new, 8'h0, r_r.len);
                        r_nxt.tdi  = step_tdi(op_new, 8'h0, r_r.ir, r_r.tx);
                    end
                end
                REG_IR:  r_nxt.ir = hwdata[IR_W-1:0];
                REG_LEN: r_nxt.len = hwdata[7:0];
                REG_TX0: r_nxt.tx[31:0] = hwdata;
                REG_TX1: r_nxt.tx[63:32] = hwdata;
                REG_TX2: r_nxt.tx[95:64] = hwdata;
                default: ;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            r_r <= HOST_RST;
        end else begin
            r_r <= r_nxt;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign hrdata    = r_r.rdata;
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign link.tck  = r_r.tck;
    assign link.tms  = r_r.tms;
    assign link.tdi  = r_r.tdi;
endmodule : jcp_host
`default_nettype wire

// ---- shared/jcp_link_if.sv ----
// Serial test port link between the host end and the device end.
// Assumes the bench joins both modports; tdo idles high when undriven.
`timescale 1ns/1ps
`default_nettype none
interface jcp_link_if;
    logic tck;
    logic tms;
    logic tdi;
    logic tdo;
    logic tdo_oe;
    wire  tdo_line = tdo_oe ? tdo : 1'b1;

    modport dev  (input tck, input tms, input tdi, output tdo, output tdo_oe);
    modport host (output tck, output tms, output tdi, input tdo_line);
endinterface : jcp_link_if
`default_nettype wire

// ---- shared/jcp_pkg.sv ----
// Constants shared by both ends of the configuration program port.
// Assumes both ends run on hclk at 40 MHz.
`default_nettype none
package jcp_pkg;
    localparam int UREG_W = 96;
    localparam int IR_W   = 5;
    localparam int ID_W   = 32;

    // Instruction codes
    localparam logic [4:0] INS_EXTEST    = 5'h00;
    localparam logic [4:0] INS_ADDR_USER = 5'h01;
    localparam logic [4:0] INS_ERASE_A   = 5'h02;
    localparam logic [4:0] INS_ERASE_B   = 5'h03;
    localparam logic [4:0] INS_VERIFY_A  = 5'h04;
    localparam logic [4:0] INS_VERIFY_B  = 5'h05;
    localparam logic [4:0] INS_PROG_A    = 5'h06;
    localparam logic [4:0] INS_PROG_B    = 5'h07;
    localparam logic [4:0] INS_AUTOCAL   = 5'h0c;
    localparam logic [4:0] INS_IDCODE    = 5'h0d;
    localparam logic [4:0] INS_SAMPLE    = 5'h1e;
    localparam logic [4:0] INS_BYPASS    = 5'h1f;

    // Timing
    localparam int CLK_PERIOD_NS = 25;
    localparam int PROG_TIME_NS  = 10000;
    localparam int CAL_TIME_NS   = 20000;
    localparam int PROG_CYC      = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CAL_CYC       = (CAL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TCK_HALF      = 4;

    // Configuration memory layout
    localparam int            CFG_SEL_BIT = 95;
    localparam logic [95:0]   CAP_MASK_B  = 96'h0000_0000_ffff_ffff_ffff_ffff;
    localparam logic [95:0]   UREG_RST    = 96'h0;
    // Arbitrary identification value, bit 0 set as the scan standard demands
    localparam logic [31:0]   ID_VALUE    = 32'h0000_0001;

    // Host sequence lengths in TCK cycles
    localparam logic [7:0] RST_STEPS = 8'd5;
    localparam logic [7:0] IR_PRE    = 8'd5;
    localparam logic [7:0] DR_PRE    = 8'd4;
    localparam logic [7:0] POST_LEN  = 8'd2;

    // Host register byte offsets
    localparam logic [7:0] REG_CMD    = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_IR     = 8'h08;
    localparam logic [7:0] REG_LEN    = 8'h0c;
    localparam logic [7:0] REG_TX0    = 8'h10;
    localparam logic [7:0] REG_TX1    = 8'h14;
    localparam logic [7:0] REG_TX2    = 8'h18;
    localparam logic [7:0] REG_RX0    = 8'h20;
    localparam logic [7:0] REG_RX1    = 8'h24;
    localparam logic [7:0] REG_RX2    = 8'h28;

    typedef enum logic [1:0] {
        OP_RESET = 2'h0,
        OP_IDLE  = 2'h1,
        OP_IR    = 2'h2,
        OP_DR    = 2'h3
    } jcp_op_type;

    typedef enum logic [3:0] {
        TAP_TLR = 4'h0, TAP_RTI = 4'h1, TAP_SDS = 4'h3, TAP_CDR = 4'h2,
        TAP_SDR = 4'h6, TAP_E1D = 4'h7, TAP_UDR = 4'h5, TAP_PDR = 4'h4,
        TAP_E2D = 4'hc, TAP_SIS = 4'hd, TAP_CIR = 4'hf, TAP_SIR = 4'he,
        TAP_E1I = 4'ha, TAP_UIR = 4'hb, TAP_PIR = 4'h9, TAP_E2I = 4'h8
    } jcp_tap_type;
endpackage : jcp_pkg
`default_nettype wire

// ---- tb/jcp_link_asserts.sv ----
// Wire checks on the serial link between host and device ends.
// Assumes host HALF of 4 and hclk as the sampling clock.
`timescale 1ns/1ps
`default_nettype none
module jcp_link_asserts (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    input wire logic tdo,
    input wire logic tdo_oe,
    input wire logic tdo_line
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // ----------------------------------------
    // Link timing and levels
    // ----------------------------------------
    a_tck_high_time: assert property ($rose(tck) |-> tck [*3] ##[1:5] !tck)
        else $error("tck high phase wrong");
    a_tck_low_time: assert property ($fell(tck) |-> !tck [*3])
        else $error("tck low phase too short");
    a_tms_on_low: assert property ($changed(tms) |-> !tck)
        else $error("tms moved while tck high");
    a_tdi_on_low: assert property ($changed(tdi) |-> !tck)
        else $error("tdi moved while tck high");
    a_tdo_held_high: assert property (tck && $past(tck) |-> $stable(tdo_line))
        else $error("tdo moved while tck high");
    a_oe_rise_low: assert property ($rose(tdo_oe) |-> !tck)
        else $error("tdo enable rose while tck high");
    a_oe_fall_low: assert property ($fell(tdo_oe) |-> !tck)
        else $error("tdo enable fell while tck high");
    a_line_idle_one: assert property (!tdo_oe |-> tdo_line)
        else $error("released tdo line not high");
    c_shift: cover property ($rose(tdo_oe));
    c_tck: cover property ($rose(tck) && tms);
    c_end: cover property ($fell(tdo_oe) ##[1:20] $rose(tck));
endmodule : jcp_link_asserts
`default_nettype wire

// ---- tb/jtag_config_program_port_tb.sv ----
// Bench joining host and device ends over the link.
// Assumes AHB-Lite zero wait states; small program and calibration counts.
`timescale 1ns/1ps
`default_nettype none
module jtag_config_program_port_tb;
    import jcp_pkg::*;
    logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
    logic [31:0] haddr = 0, hwdata = 0, hrdata;
    logic [1:0]  htrans = 0;
    logic [2:0]  hsize = 3'h2;
    logic        hreadyout, hresp, susp, cal, s_seen = 0, c_seen = 0;
    wire         hready = hreadyout;
    logic [95:0] cfg_a, cfg_b, rx;
    int          err_count = 0, cmp_count = 0;
    always #12.5 hclk = ~hclk;
    always @(posedge hclk) begin
        if (susp === 1'b1) s_seen <= 1'b1;
        if (cal === 1'b1) c_seen <= 1'b1;
    end
    jcp_link_if i_jcp_link_if ();
    jcp_device #(.PROG_CYCLES(10), .CAL_CYCLES(20)) i_jcp_device (.hclk(hclk), .hresetn(hresetn),
        .link(i_jcp_link_if.dev), .cfg_a(cfg_a), .cfg_b(cfg_b), .normal_op_suspended(susp), .cal_active(cal));
    jcp_host i_jcp_host (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .link(i_jcp_link_if.host));
    jcp_link_asserts i_jcp_link_asserts (.hclk(hclk), .hresetn(hresetn), .tck(i_jcp_link_if.tck),
        .tms(i_jcp_link_if.tms), .tdi(i_jcp_link_if.tdi), .tdo(i_jcp_link_if.tdo),
        .tdo_oe(i_jcp_link_if.tdo_oe), .tdo_line(i_jcp_link_if.tdo_line));
    // ----------------------------------------
    // Bus and scan tasks
    // ----------------------------------------
    task automatic stop_test;
        $display("Compares %0d, mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : stop_test
    task automatic chk(input logic ok, input string m);
        cmp_count++;
        if (ok !== 1'b1) begin
            err_count++;
            $display("[FAIL] %0t %s", $time, m);
        end
    endtask : chk
    task automatic wt;
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hready !== 1'b1 && n < 64);
        if (n >= 64) begin
            err_count++;
            stop_test();
        end
    endtask : wt
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        hsel   <= 1'b1;
        haddr  <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'h2;
        wt();
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wt();
        q = hrdata;
    endtask : bus
    task automatic op(input logic [1:0] c, input logic [4:0] ir, input logic [7:0] n, input logic [95:0] tx);
        logic [31:0] q;
        int          k;
        bus(1'b1, REG_IR, {27'h0, ir}, q);
        bus(1'b1, REG_LEN, {24'h0, n}, q);
        for (k = 0; k < 3; k++) bus(1'b1, REG_TX0 + 8'(4 * k), tx[32 * k +: 32], q);
        bus(1'b1, REG_CMD, {30'h0, c}, q);
        k = 0;
        do begin
            bus(1'b0, REG_STATUS, 32'h0, q);
            k++;
        end while (q[0] !== 1'b0 && k < 2000);
        if (k >= 2000) begin
            err_count++;
            stop_test();
        end
        for (k = 0; k < 3; k++) begin
            bus(1'b0, REG_RX0 + 8'(4 * k), 32'h0, q);
            rx[32 * k +: 32] = q;
        end
    endtask : op
    task automatic prog(input logic [4:0] ins, input logic [95:0] d);
        op(2'h2, INS_ADDR_USER, 8'd0, 96'h0);
        op(2'h3, 5'h0, 8'd96, d);
        op(2'h2, ins, 8'd0, 96'h0);
        op(2'h1, 5'h0, 8'd4, 96'h0);
    endtask : prog
    task automatic rdback(input logic [4:0] ins);
        op(2'h2, ins, 8'd0, 96'h0);
        op(2'h2, INS_ADDR_USER, 8'd0, 96'h0);
        op(2'h3, 5'h0, 8'd96, 96'h0);
    endtask : rdback
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_id;
        logic [31:0] q;
        op(2'h3, 5'h0, 8'd32, 96'h0);
        chk(rx[31:0] === ID_VALUE, "id after reset");
        bus(1'b0, 8'h40, 32'h0, q);
        chk(q === 32'h0, "unmapped read");
        chk(hresp === 1'b0, "okay response");
        $display("t_id done");
    endtask : t_id
    task automatic t_byp;
        logic [4:0] c [4] = '{INS_EXTEST, INS_SAMPLE, INS_BYPASS, 5'h08};
        for (int i = 0; i < 4; i++) begin
            op(2'h2, c[i], 8'd0, 96'h0);
            op(2'h3, 5'h0, 8'd2, 96'h1);
            chk(rx[1:0] === 2'b10, "bypass path");
        end
        op(2'h2, INS_IDCODE, 8'd0, 96'h0);
        op(2'h3, 5'h0, 8'd32, 96'h0);
        chk(rx[31:0] === ID_VALUE, "id instruction");
        $display("t_byp done");
    endtask : t_byp
    task automatic t_mem;
        logic [95:0] p1, p2;
        p1 = 96'h0123_4567_89ab_cdef_0f0f_0f0f;
        p2 = 96'h0000_0000_f000_0000_0000_00f0;
        prog(INS_PROG_A, p1);
        chk(cfg_a === p1 && s_seen === 1'b1, "program a");
        prog(INS_PROG_A, p2);
        chk(cfg_a === (p1 | p2), "program sets only");
        rdback(INS_VERIFY_A);
        chk(rx === (p1 | p2), "verify a");
        op(2'h2, INS_ERASE_A, 8'd0, 96'h0);
        op(2'h1, 5'h0, 8'd4, 96'h0);
        chk(cfg_a === 96'h0, "erase a");
        prog(INS_PROG_B, {96{1'b1}});
        chk(cfg_b === CAP_MASK_B, "b keeps cap bits");
        op(2'h2, INS_ERASE_B, 8'd0, 96'h0);
        op(2'h1, 5'h0, 8'd4, 96'h0);
        chk(cfg_b === 96'h0, "erase b");
        prog(INS_PROG_A, 96'h8000_0000_0000_0000_0000_0001);
        rdback(INS_VERIFY_A);
        chk(rx === 96'h0, "verify a with select set");
        $display("t_mem done");
    endtask : t_mem
    task automatic t_cal;
        op(2'h2, INS_AUTOCAL, 8'd0, 96'h0);
        op(2'h0, 5'h0, 8'd0, 96'h0);
        chk(c_seen === 1'b1, "calibration ran");
        op(2'h3, 5'h0, 8'd32, 96'h0);
        chk(rx[31:0] === ID_VALUE, "id after port reset");
        $display("t_cal done");
    endtask : t_cal
    initial begin
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_id();
        t_byp();
        t_mem();
        t_cal();
        stop_test();
    end
endmodule : jtag_config_program_port_tb
`default_nettype wire
